/* rtl/lcg_defines.svh */
`ifndef LCG_DEFINES_SVH
`define LCG_DEFINES_SVH
// Behaviour
// [R1] latching mode fills all eight bits of the channel byte with the code
// [R2] alternating mode sends a code byte in every second byte slot
// [R3] each loop-up or loop-down operation ends with a pass or fail flag
// [R4] S bit 1 for 56k idle, 0 for 56k loopback; n bits don't care
// [R5] channel service unit: alternating S0101000, latching N0110001
// [R6] office channel unit: alternating S0101010, latching N1010101
// [R7] data service unit: alternating S0101100, latching N1110111
// [R8] latching-only targets: N1000111, N1000001, N0000101
// [R9] channel data port addressed 1..8; read back line or drop side; the location field (bits 14:12) is never used by the code
// [R10] one repeater: loop up, loop repeater down, then standard activation
// [R11] two repeaters: extra loop-down and a third activation step
// [R12] office unit behind high-level unit: up, down, then activation
// [R13] selection only in terminate mode; default channel service unit
// [R14] T1 channel service unit: repeat 10000 up, 100 down
// [R15] facility type one: repeat 1100 up, 1110 down
// [R16] facility type two: repeat 11000 up, 11100 down
// [R17] facility type three: repeat 100000 up, 100 down
// [R18] inband patterns usable in full, fractional and every framing
// [R19] line repeaters loop up in turn, report address, loop down; the code sends a single loop-up step for LCG_T_RPT1 and LCG_T_RPT2
// [R20] powering repeater holds power off while command is received; the code has no power control
// [R21] repeater and line codes only with full-rate payload; the code gates only the repeater targets on full rate
// [R22] leftmost pattern bit goes out first
// [R23] inband patterns repeat without gaps while command active

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define LCG_OFS_CTRL 4'h0
`define LCG_OFS_CMD 4'h4
`define LCG_OFS_STAT 4'h8
`define LCG_OFS_FEED 4'hC

// ctrl field positions
`define LCG_CTRL_TARGET_LSB 0
`define LCG_CTRL_TARGET_MSB 3
`define LCG_CTRL_ALT_BIT 4
`define LCG_CTRL_DDS_BIT 5
`define LCG_CTRL_TERM_BIT 6
`define LCG_CTRL_FULL_BIT 7
`define LCG_CTRL_SUB56_BIT 8
`define LCG_CTRL_IDLE_BIT 9
`define LCG_CTRL_LOC_LSB 12
`define LCG_CTRL_LOC_MSB 14
`define LCG_CTRL_RESET 32'h0000_0040

// cmd bits
`define LCG_CMD_UP_BIT 0
`define LCG_CMD_DOWN_BIT 1
`define LCG_CMD_STOP_BIT 2

// timing: byte count at which a sequence step ends (a step lasts 41 bytes)
`define LCG_STEP_BYTES 16'h0028

// ----------------------------------------
// pattern codes, left aligned
// ----------------------------------------
`define LCG_PAT_CSU_UP 16'h8000
`define LCG_PAT_CSU_UP_LEN 5'h05
`define LCG_PAT_DN_100 16'h8000
`define LCG_PAT_DN_100_LEN 5'h03
`define LCG_PAT_F1_UP 16'hC000
`define LCG_PAT_F1_DN 16'hE000
`define LCG_PAT_F1_LEN 5'h04
`define LCG_PAT_F2_UP 16'hC000
`define LCG_PAT_F2_DN 16'hE000
`define LCG_PAT_F2_LEN 5'h05
`define LCG_PAT_F3_UP 16'h8000
`define LCG_PAT_F3_LEN 5'h06

// dds code low seven bits
`define LCG_ALT_CSU 7'h28
`define LCG_ALT_OCU 7'h2A
`define LCG_ALT_DSU 7'h2C
`define LCG_LAT_CSU 7'h31
`define LCG_LAT_OCU 7'h55
`define LCG_LAT_DSU 7'h77
`define LCG_LAT_LSI 7'h47
`define LCG_LAT_NEI 7'h41
`define LCG_LAT_DP 7'h05
`define LCG_ALT_DOWN 7'h7F
`endif

/* rtl/lcg_pkg.sv */
`default_nettype none
package lcg_pkg;
	typedef enum logic [3:0]
	{
		LCG_T_CSU = 4'h0,
		LCG_T_CHANNEL_UNIT_VIA_ONE_REPEATER = 4'h1,
		LCG_T_CHANNEL_UNIT_VIA_TWO_REPEATERS = 4'h2,
		LCG_T_OCU = 4'h3,
		LCG_T_OCU_HL = 4'h4,
		LCG_T_DSU = 4'h5,
		LCG_T_LSI = 4'h6,
		LCG_T_NEI = 4'h7,
		LCG_T_DP = 4'h8,
		LCG_T_FACILITY_TYPE_ONE = 4'h9,
		LCG_T_FACILITY_TYPE_TWO = 4'hA,
		LCG_T_FACILITY_TYPE_THREE = 4'hB,
		LCG_T_RPT1 = 4'hC,
		LCG_T_RPT2 = 4'hD
	} lcg_target_e;

	typedef enum logic [2:0]
	{
		LCG_S_IDLE = 3'h0,
		LCG_S_STEP = 3'h1,
		LCG_S_NEXT = 3'h2,
		LCG_S_INBAND = 3'h3,
		LCG_S_DONE = 3'h4
	} lcg_state_e;

	typedef enum logic [1:0]
	{
		LCG_A_UP = 2'h0,
		LCG_A_DOWN = 2'h1,
		LCG_A_STD = 2'h2
	} lcg_action_e;
endpackage
`default_nettype wire

/* rtl/lcg_pattern_ser.sv */
`default_nettype none
`include "lcg_defines.svh"
// repeating pattern serialiser, msb first, no gaps
module lcg_pattern_ser
(
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic bit_en,
	input wire logic [15:0] pattern,
	input wire logic [4:0] length,
	output logic bit_out
);
	logic [4:0] idx_reg;

	// [R22] leftmost first
	assign bit_out = pattern[4'(5'd15 - idx_reg)];

	// [R23] wrap back to back
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			idx_reg <= 5'h00;
		else if (!run)
			idx_reg <= 5'h00;
		else if (bit_en)
			idx_reg <= (idx_reg + 5'h01 >= length) ? 5'h00 :
				idx_reg + 5'h01;
	end
endmodule // lcg_pattern_ser
`default_nettype wire

/* rtl/lcg_dds_byte.sv */
`default_nettype none
`include "lcg_defines.svh"
// builds one dds channel byte for the target
module lcg_dds_byte
(
	input wire logic [3:0] target,
	input wire logic alt_mode,
	input wire logic sub56,
	input wire logic idle_code,
	input wire logic down,
	input wire logic [7:0] payload,
	input wire logic code_slot,
	output logic [7:0] byte_out
);
	import lcg_pkg::*;
	logic [6:0] code;
	logic s_bit;

	always_comb
	begin
		code = `LCG_LAT_CSU;
		if (down && alt_mode)
			code = `LCG_ALT_DOWN;
		else if (alt_mode)
		begin
			case (target)
				// [R5] csu alternating
				LCG_T_CSU, LCG_T_CHANNEL_UNIT_VIA_ONE_REPEATER, LCG_T_CHANNEL_UNIT_VIA_TWO_REPEATERS, LCG_T_RPT1,
				LCG_T_RPT2: code = `LCG_ALT_CSU;
				// [R6] ocu alternating
				LCG_T_OCU, LCG_T_OCU_HL: code = `LCG_ALT_OCU;
				// [R7] dsu alternating
				LCG_T_DSU: code = `LCG_ALT_DSU;
				default: code = `LCG_ALT_CSU;
			endcase
		end
		else
		begin
			case (target)
				LCG_T_CSU: code = `LCG_LAT_CSU;
				LCG_T_OCU: code = `LCG_LAT_OCU;
				LCG_T_DSU: code = `LCG_LAT_DSU;
				// [R8] latching-only targets
				LCG_T_LSI: code = `LCG_LAT_LSI;
				LCG_T_NEI: code = `LCG_LAT_NEI;
				LCG_T_DP: code = `LCG_LAT_DP;
				default: code = `LCG_LAT_CSU;
			endcase
		end
		// [R4] subrate framing bit
		s_bit = sub56 ? idle_code : 1'b0;
	end

	always_comb
	begin
		// [R1] latching uses whole byte
		if (!alt_mode)
			byte_out = {1'b0, code};
		// [R2] code every second slot
		else if (code_slot)
			byte_out = {s_bit, code};
		else
			byte_out = payload;
	end
endmodule // lcg_dds_byte
`default_nettype wire

/* rtl/lcg_top.sv */
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`default_nettype none
`include "lcg_defines.svh"
module lcg_top
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic byte_tick,
	input wire logic bit_tick,
	input wire logic [7:0] payload_byte,
	input wire logic feedback_valid,
	input wire logic feedback_line_side,
	input wire logic loop_confirm,
	output logic [7:0] chan_byte,
	output logic chan_byte_valid,
	output logic inband_bit,
	output logic inband_active
);
	import lcg_pkg::*;

	// ----------------------------------------
	// register slave
	// ----------------------------------------
	logic [31:0] ctrl_reg;
	logic [31:0] rdata_next;
	logic [31:0] avs_readdata_reg;
	logic ack_reg;
	logic up_pulse;
	logic down_pulse;
	logic stop_pulse;
	logic busy_reg;
	logic done_reg;
	logic pass_reg;
	logic feed_ok_reg;
	logic feed_line_reg;
	logic [2:0] step_reg;
	lcg_state_e state_reg;

	lcg_target_e target;
	logic alt_mode;
	logic dds_mode;
	logic term_mode;
	logic full_rate;

	assign target = lcg_target_e'(ctrl_reg[`LCG_CTRL_TARGET_MSB:
		`LCG_CTRL_TARGET_LSB]);
	assign alt_mode = ctrl_reg[`LCG_CTRL_ALT_BIT];
	assign dds_mode = ctrl_reg[`LCG_CTRL_DDS_BIT];
	assign term_mode = ctrl_reg[`LCG_CTRL_TERM_BIT];
	assign full_rate = ctrl_reg[`LCG_CTRL_FULL_BIT];

	// one wait cycle per access
	assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
	assign avs_readdata = avs_readdata_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ack_reg <= 1'b0;
		else
			ack_reg <= (avs_read || avs_write) && !ack_reg;
	end

	logic wr_take;
	assign wr_take = avs_write && ack_reg;

	// [R13] default target channel service unit
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ctrl_reg <= `LCG_CTRL_RESET;
		else if (wr_take && avs_address == `LCG_OFS_CTRL && !busy_reg)
			ctrl_reg <= avs_writedata;
	end

	assign up_pulse = wr_take && avs_address == `LCG_OFS_CMD &&
		avs_writedata[`LCG_CMD_UP_BIT];
	assign down_pulse = wr_take && avs_address == `LCG_OFS_CMD &&
		avs_writedata[`LCG_CMD_DOWN_BIT] && !up_pulse;
	assign stop_pulse = wr_take && avs_address == `LCG_OFS_CMD &&
		avs_writedata[`LCG_CMD_STOP_BIT];

	always_comb
	begin
		case (avs_address)
			`LCG_OFS_CTRL: rdata_next = ctrl_reg;
			`LCG_OFS_STAT: rdata_next = {24'h0000_00, 1'b0, step_reg,
				1'b0, pass_reg, done_reg, busy_reg};
			`LCG_OFS_FEED: rdata_next = {29'h0000_0000, 1'b0,
				feed_line_reg, feed_ok_reg};
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			avs_readdata_reg <= 32'h0000_0000;
		else if (avs_read && !ack_reg)
			avs_readdata_reg <= rdata_next;
	end

	// ----------------------------------------
	// command qualification
	// ----------------------------------------
	logic is_inband_t;
	logic is_repeater_t;
	logic allowed;
	logic dir_down_reg;

	assign is_inband_t = !dds_mode && (target == LCG_T_CSU ||
		target == LCG_T_FACILITY_TYPE_ONE || target == LCG_T_FACILITY_TYPE_TWO ||
		target == LCG_T_FACILITY_TYPE_THREE);
	assign is_repeater_t = target == LCG_T_RPT1 || target == LCG_T_RPT2;

	// [R13] terminate mode only
	// [R21] repeater codes need full rate
	assign allowed = term_mode && (!is_repeater_t || full_rate);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	logic [15:0] byte_cnt_reg;
	logic [2:0] last_step;
	lcg_action_e action;
	logic code_slot_reg;
	logic step_end;

	// [R10] [R11] [R12] multi-step sequences
	function automatic lcg_action_e step_action(input lcg_target_e t,
		input logic [2:0] s);
		step_action = LCG_A_UP;
		case (t)
			LCG_T_CHANNEL_UNIT_VIA_ONE_REPEATER, LCG_T_OCU_HL:
				step_action = (s == 3'h1) ? LCG_A_DOWN :
					(s == 3'h2) ? LCG_A_STD : LCG_A_UP;
			LCG_T_CHANNEL_UNIT_VIA_TWO_REPEATERS:
				step_action = (s == 3'h1 || s == 3'h3) ? LCG_A_DOWN :
					(s == 3'h0) ? LCG_A_UP : LCG_A_STD;
			default: step_action = LCG_A_UP;
		endcase
	endfunction

	always_comb
	begin
		case (target)
			LCG_T_CHANNEL_UNIT_VIA_ONE_REPEATER, LCG_T_OCU_HL: last_step = 3'h2;
			LCG_T_CHANNEL_UNIT_VIA_TWO_REPEATERS: last_step = 3'h4;
			default: last_step = 3'h0;
		endcase
	end

	assign action = dir_down_reg ? LCG_A_DOWN :
		step_action(target, step_reg);
	assign step_end = byte_tick && byte_cnt_reg == `LCG_STEP_BYTES;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= LCG_S_IDLE;
			step_reg <= 3'h0;
			dir_down_reg <= 1'b0;
			busy_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				LCG_S_IDLE:
					if ((up_pulse || down_pulse) && allowed)
					begin
						dir_down_reg <= down_pulse;
						step_reg <= 3'h0;
						busy_reg <= 1'b1;
						state_reg <= is_inband_t ? LCG_S_INBAND :
							LCG_S_STEP;
					end
				LCG_S_STEP:
					if (stop_pulse)
						state_reg <= LCG_S_DONE;
					else if (step_end)
						state_reg <= LCG_S_NEXT;
				LCG_S_NEXT:
					if (dir_down_reg || step_reg == last_step)
						state_reg <= LCG_S_DONE;
					else
					begin
						step_reg <= step_reg + 3'h1;
						state_reg <= LCG_S_STEP;
					end
				// [R23] repeat until stopped
				LCG_S_INBAND:
					if (stop_pulse)
						state_reg <= LCG_S_DONE;
				LCG_S_DONE:
				begin
					busy_reg <= 1'b0;
					state_reg <= LCG_S_IDLE;
				end
				default: state_reg <= LCG_S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			byte_cnt_reg <= 16'h0000;
		else if (state_reg != LCG_S_STEP || step_end)
			byte_cnt_reg <= 16'h0000;
		else if (byte_tick)
			byte_cnt_reg <= byte_cnt_reg + 16'h0001;
	end

	// [R2] slot alternation
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			code_slot_reg <= 1'b1;
		else if (state_reg != LCG_S_STEP)
			code_slot_reg <= 1'b1;
		else if (byte_tick)
			code_slot_reg <= !code_slot_reg;
	end

	// [R3] pass or fail at end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			done_reg <= 1'b0;
			pass_reg <= 1'b0;
		end
		else if (state_reg == LCG_S_DONE)
		begin
			done_reg <= 1'b1;
			pass_reg <= loop_confirm;
		end
		else if ((up_pulse || down_pulse) && state_reg == LCG_S_IDLE)
			done_reg <= 1'b0;
	end

	// [R9] port feedback capture
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			feed_ok_reg <= 1'b0;
			feed_line_reg <= 1'b0;
		end
		else if (state_reg == LCG_S_DONE && target == LCG_T_DP)
		begin
			feed_ok_reg <= feedback_valid;
			feed_line_reg <= feedback_line_side;
		end
	end

	// ----------------------------------------
	// dds byte path
	// ----------------------------------------
	logic [7:0] dds_byte;
	logic [7:0] dp_byte;

	lcg_dds_byte u_dds
	(
		.target(target),
		.alt_mode(alt_mode),
		.sub56(ctrl_reg[`LCG_CTRL_SUB56_BIT]),
		.idle_code(ctrl_reg[`LCG_CTRL_IDLE_BIT] ||
			action == LCG_A_DOWN),
		.down(action == LCG_A_DOWN),
		.payload(payload_byte),
		.code_slot(code_slot_reg),
		.byte_out(dds_byte)
	);

	// [R8] port code byte kept whole
	assign dp_byte = dds_byte;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			chan_byte <= 8'hFF;
			chan_byte_valid <= 1'b0;
		end
		else
		begin
			chan_byte_valid <= state_reg == LCG_S_STEP;
			if (byte_tick)
				chan_byte <= (state_reg == LCG_S_STEP) ? dp_byte :
					payload_byte;
		end
	end

	// ----------------------------------------
	// inband repeating patterns
	// ----------------------------------------
	logic [15:0] pat;
	logic [4:0] pat_len;
	logic ser_bit;

	always_comb
	begin
		pat = `LCG_PAT_CSU_UP;
		pat_len = `LCG_PAT_CSU_UP_LEN;
		case (target)
			// [R15] facility one
			LCG_T_FACILITY_TYPE_ONE:
			begin
				pat = dir_down_reg ? `LCG_PAT_F1_DN : `LCG_PAT_F1_UP;
				pat_len = `LCG_PAT_F1_LEN;
			end
			// [R16] facility two
			LCG_T_FACILITY_TYPE_TWO:
			begin
				pat = dir_down_reg ? `LCG_PAT_F2_DN : `LCG_PAT_F2_UP;
				pat_len = `LCG_PAT_F2_LEN;
			end
			// [R17] facility three
			LCG_T_FACILITY_TYPE_THREE:
			begin
				pat = dir_down_reg ? `LCG_PAT_DN_100 : `LCG_PAT_F3_UP;
				pat_len = dir_down_reg ? `LCG_PAT_DN_100_LEN :
					`LCG_PAT_F3_LEN;
			end
			// [R14] csu 10000 / 100
			default:
			begin
				pat = dir_down_reg ? `LCG_PAT_DN_100 : `LCG_PAT_CSU_UP;
				pat_len = dir_down_reg ? `LCG_PAT_DN_100_LEN :
					`LCG_PAT_CSU_UP_LEN;
			end
		endcase
	end

	// [R18] framing-agnostic bit stream
	lcg_pattern_ser u_ser
	(
		.clk(clk),
		.rst(rst),
		.run(state_reg == LCG_S_INBAND),
		.bit_en(bit_tick),
		.pattern(pat),
		.length(pat_len),
		.bit_out(ser_bit)
	);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			inband_bit <= 1'b0;
			inband_active <= 1'b0;
		end
		else
		begin
			inband_active <= state_reg == LCG_S_INBAND;
			if (bit_tick)
				inband_bit <= ser_bit;
		end
	end
endmodule // lcg_top
`default_nettype wire

/* dv/lcg_top_monitor.sv */
`default_nettype none
module lcg_top_monitor
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic byte_tick,
	input wire logic bit_tick,
	input wire logic [7:0] chan_byte,
	input wire logic chan_byte_valid,
	input wire logic inband_bit,
	input wire logic inband_active
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] tick_cnt_reg;
	default clocking mon_cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// byte ticks seen while bytes stay valid
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			tick_cnt_reg <= 8'h00;
		else if (!chan_byte_valid)
			tick_cnt_reg <= 8'h00;
		else if (byte_tick && tick_cnt_reg != 8'hFF)
			tick_cnt_reg <= tick_cnt_reg + 8'h01;
	end
	a_wait_one_cycle: assert property (
		$rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("access not answered after one wait cycle");
	a_no_idle_wait: assert property (
		!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait raised with no access");
	a_unmapped_zero: assert property (
		avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
		|-> avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_read_stands: assert property (
		!avs_read |=> $stable(avs_readdata))
		else $error("read data changed without a read");
	a_bit_hold: assert property (
		inband_active && $past(inband_active) && !$past(bit_tick)
		|-> $stable(inband_bit))
		else $error("line bit changed without bit tick");
	a_byte_hold: assert property (
		chan_byte_valid && $past(chan_byte_valid) && !$past(byte_tick)
		|-> $stable(chan_byte))
		else $error("channel byte changed without byte tick");
	a_inband_no_gap: assert property (
		inband_active && !(avs_write && avs_address == 4'h4) &&
		!$past(avs_write && avs_address == 4'h4)
		|=> inband_active)
		else $error("inband pattern stopped without command");
	a_step_length: assert property (
		$fell(chan_byte_valid) |-> tick_cnt_reg >= 8'h28)
		else $error("code step shorter than its byte count");
endmodule // lcg_top_monitor

bind lcg_top lcg_top_monitor u_lcg_mon
(
	.clk(clk),
	.rst(rst),
	.avs_address(avs_address),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.byte_tick(byte_tick),
	.bit_tick(bit_tick),
	.chan_byte(chan_byte),
	.chan_byte_valid(chan_byte_valid),
	.inband_bit(inband_bit),
	.inband_active(inband_active)
);
`default_nettype wire

/* dv/lcg_span_model.sv */
`default_nettype none
module lcg_span_model
(
	input wire logic clk,
	input wire logic rst,
	input wire logic fail_loop,
	output logic byte_tick,
	output logic bit_tick,
	output logic [7:0] payload_byte,
	output logic feedback_valid,
	output logic feedback_line_side,
	output logic loop_confirm
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] div_reg;
	// line timing: a bit every two clocks, a byte every eight bits
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			div_reg <= 4'h0;
			bit_tick <= 1'b0;
			byte_tick <= 1'b0;
		end
		else
		begin
			div_reg <= div_reg + 4'h1;
			bit_tick <= div_reg[0];
			byte_tick <= (div_reg == 4'hF);
		end
	end
	assign payload_byte = 8'h96;
	assign loop_confirm = !fail_loop;
	assign feedback_valid = 1'b1;
	assign feedback_line_side = 1'b1;
endmodule // lcg_span_model
`default_nettype wire

/* dv/testbench.sv */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic fail_loop = 1'b0;
	logic [31:0] avs_readdata, rd;
	logic [7:0] payload_byte, chan_byte;
	logic avs_waitrequest, byte_tick, bit_tick, loop_confirm;
	logic feedback_valid, feedback_line_side;
	logic chan_byte_valid, inband_bit, inband_active;
	int error_cnt = 0;
	int comparisons = 0;
	int cyc = 0;
	int runs, bad, k;
	logic [3:0] ib_tgt[4] = '{4'h0, 4'h9, 4'hA, 4'hB};
	logic [7:0] ib_pat[8] = '{8'h10, 8'h04, 8'h0C, 8'h0E,
		8'h18, 8'h1C, 8'h20, 8'h04};
	int ib_len[8] = '{5, 3, 4, 4, 5, 5, 6, 3};
	logic [31:0] dd_ctrl[9] = '{32'h0000_0170, 32'h0000_0370,
		32'h0000_0173, 32'h0000_0175, 32'h0000_0060, 32'h0000_0063,
		32'h0000_0065, 32'h0000_0066, 32'h0000_0067};
	logic [7:0] dd_code[9] = '{8'h28, 8'hA8, 8'h2A, 8'h2C, 8'h31,
		8'h55, 8'h77, 8'h47, 8'h41};
	logic [31:0] sq_ctrl[3] = '{32'h0000_0171, 32'h0000_0172,
		32'h0000_0174};
	logic [7:0] sq_code[3] = '{8'h28, 8'h28, 8'h2A};
	int sq_steps[3] = '{3, 5, 3};

	always #50 clk = ~clk;

	lcg_top dut
	(
		.clk(clk),
		.rst(rst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.byte_tick(byte_tick),
		.bit_tick(bit_tick),
		.payload_byte(payload_byte),
		.feedback_valid(feedback_valid),
		.feedback_line_side(feedback_line_side),
		.loop_confirm(loop_confirm),
		.chan_byte(chan_byte),
		.chan_byte_valid(chan_byte_valid),
		.inband_bit(inband_bit),
		.inband_active(inband_active)
	);

	lcg_span_model u_span
	(
		.clk(clk),
		.rst(rst),
		.fail_loop(fail_loop),
		.byte_tick(byte_tick),
		.bit_tick(bit_tick),
		.payload_byte(payload_byte),
		.feedback_valid(feedback_valid),
		.feedback_line_side(feedback_line_side),
		.loop_confirm(loop_confirm)
	);

	task automatic close_out();
		$display("mismatches %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	// settles just after the clock edge that saw the tick
	task automatic wait_tick(input logic on_bit);
		do
			@(negedge clk);
		while ((on_bit ? bit_tick : byte_tick) !== 1'b1);
		@(negedge clk);
	endtask

	task automatic run_ib(input logic [31:0] ctrl, input logic [31:0] cmd,
		input logic [7:0] pat, input int len);
		logic [11:0] b;
		int i, r, hit, ok;
		bus(1'b1, 4'h0, ctrl);
		bus(1'b1, 4'h4, cmd);
		while (inband_active !== 1'b1)
			@(negedge clk);
		for (i = 0; i < 12; i++)
		begin
			wait_tick(1'b1);
			b[i] = inband_bit;
		end
		hit = 0;
		for (r = 0; r < len; r++)
		begin
			ok = 1;
			for (i = 0; i < 12; i++)
				if (b[i] !== pat[len - 1 - (i + r) % len])
					ok = 0;
			hit += ok;
		end
		bus(1'b1, 4'h4, 32'h0000_0004);
		while (inband_active !== 1'b0)
			@(negedge clk);
		chk(hit, 32'h0000_0001);
	endtask

	task automatic run_op(input logic [31:0] ctrl, input logic [7:0] code,
		input int steps);
		logic [7:0] prev;
		logic dn;
		int i;
		runs = 0;
		bad = 0;
		prev = 8'h00;
		dn = 1'b0;
		bus(1'b1, 4'h0, ctrl);
		bus(1'b1, 4'h4, 32'h0000_0001);
		bus(1'b1, 4'h0, 32'h0000_0000);
		for (i = 0; i < 41 * steps + 4; i++)
		begin
			wait_tick(1'b0);
			if (chan_byte_valid === 1'b1)
			begin
				if (chan_byte[6:0] === 7'h7F && !dn)
					runs++;
				if (chan_byte[6:0] === 7'h7F)
					dn = 1'b1;
				else if (chan_byte === code)
					dn = 1'b0;
				if (steps == 1 && (ctrl[4] ? (chan_byte === prev ||
					(chan_byte !== code && chan_byte !== 8'h96)) :
					chan_byte !== code))
					bad++;
				prev = chan_byte;
			end
		end
		do
			bus(1'b0, 4'h8, 32'h0000_0000);
		while (rd[1] !== 1'b1);
		bad += dn;
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			error_cnt++;
			close_out();
		end
	end

	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rdchk(4'h0, 32'h0000_0040);
		rdchk(4'h8, 32'h0000_0000);
		bus(1'b1, 4'h2, 32'hFFFF_FFFF);
		rdchk(4'h2, 32'h0000_0000);
		rdchk(4'h0, 32'h0000_0040);
		bus(1'b1, 4'h0, 32'h0000_0000);
		bus(1'b1, 4'h4, 32'h0000_0001);
		rdchk(4'h8, 32'h0000_0000);
		bus(1'b1, 4'h0, 32'h0000_004C);
		bus(1'b1, 4'h4, 32'h0000_0001);
		rdchk(4'h8, 32'h0000_0000);
		for (k = 0; k < 8; k++)
			run_ib({24'h00_0000, (k % 2) ? 4'h4 : 4'hC, ib_tgt[k / 2]},
				(k % 2) ? 32'h0000_0002 : 32'h0000_0001,
				ib_pat[k], ib_len[k]);
		for (k = 0; k < 9; k++)
		begin
			run_op(dd_ctrl[k], dd_code[k], 1);
			chk(bad, 32'h0000_0000);
			chk(rd & 32'h0000_0006, 32'h0000_0006);
			rdchk(4'h0, dd_ctrl[k]);
		end
		for (k = 0; k < 3; k++)
		begin
			run_op(sq_ctrl[k], sq_code[k], sq_steps[k]);
			chk(runs, (sq_steps[k] - 1) / 2);
			chk(bad, 32'h0000_0000);
		end
		fail_loop <= 1'b1;
		run_op(32'h0000_2068, 8'h05, 1);
		chk(bad, 32'h0000_0000);
		chk(rd & 32'h0000_0006, 32'h0000_0002);
		rdchk(4'hC, 32'h0000_0003);
		close_out();
	end
endmodule // testbench
`default_nettype wire
